// [hw/fmd_pkg.sv]
// Shared constants for the fan ramp and floor duty controller
package fmd_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DUTY_W    = 8;
    localparam int TEMP_W    = 8;
    localparam int ADDR_W    = 8;
    localparam int RATE_W    = 3;
    localparam int NUM_CH    = 3;
    localparam int SLOT_CNT_W = 25;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_ACOU_B  = 8'h63;
    localparam logic [ADDR_W-1:0] ADDR_FLOOR_1 = 8'h64;
    localparam logic [ADDR_W-1:0] ADDR_FLOOR_2 = 8'h65;
    localparam logic [ADDR_W-1:0] ADDR_FLOOR_3 = 8'h66;
    localparam logic [ADDR_W-1:0] ADDR_START_1 = 8'h67;
    localparam logic [ADDR_W-1:0] ADDR_START_L = 8'h68;
    localparam logic [ADDR_W-1:0] ADDR_START_2 = 8'h69;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [DUTY_W-1:0] RST_ACOU_B = 8'h00;
    localparam logic [DUTY_W-1:0] RST_FLOOR  = 8'h80;
    localparam logic [TEMP_W-1:0] RST_START  = 8'h5A;
    localparam logic [DUTY_W-1:0] DUTY_OFF   = 8'h00;
    localparam logic [DUTY_W-1:0] RDATA_NONE = 8'h00;

    // ------------------------------------------------------------
    // Fields of the acoustic control register
    // ------------------------------------------------------------
    localparam int OUT3_RATE_LSB = 0;
    localparam int OUT3_ON_BIT   = 3;
    localparam int OUT2_RATE_LSB = 4;
    localparam int OUT2_ON_BIT   = 7;

    // Duty increase per time slot for each rate code
    localparam logic [DUTY_W-1:0] RAMP_STEP [0:7] = '{
        8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30
    };

    // ------------------------------------------------------------
    // Time slot
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLOT_TIME_NS  = 205000000;
    localparam int SLOT_CYCLES_DFLT = SLOT_TIME_NS / CLK_PERIOD_NS;

endpackage

// [hw/fmd_ch_if.sv]
// Per-channel carrier between the controller, duty gate and ramp
interface fmd_ch_if;
    import fmd_pkg::*;
    logic [TEMP_W-1:0] temp;
    logic [TEMP_W-1:0] start;
    logic [DUTY_W-1:0] floor;
    logic [DUTY_W-1:0] calc;
    logic [DUTY_W-1:0] target;
    logic              on;
    logic [RATE_W-1:0] rate;
    logic              tick;
    logic [DUTY_W-1:0] duty;

    modport gate (input temp, start, floor, calc, output target);
    modport ramp (input target, on, rate, tick, output duty);
endinterface

// [hw/fmd_duty_gate.sv]
// Turns a channel temperature into the duty that its fan should reach
module fmd_duty_gate (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    // Channel
    fmd_ch_if.gate    ch
);
    import fmd_pkg::*;

    logic [DUTY_W-1:0] target_reg;
    logic [DUTY_W-1:0] target_next;

    // Below the start temperature the fan stays off; above it the span
    // result is never allowed under the floor duty
    always_comb begin
        target_next = DUTY_OFF;
        if (ch.temp > ch.start) begin // R11
            target_next = (ch.calc < ch.floor) ? ch.floor : ch.calc; // R07
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            target_reg <= DUTY_OFF;
        end else begin
            target_reg <= target_next;
        end
    end

    assign ch.target = target_reg;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_off_below: assert property ( // R11
        (ch.temp <= ch.start) |=> (ch.target == DUTY_OFF))
        else $error("fan target not off below start temperature");

    chk_floor_hold: assert property ( // R07
        (ch.temp > ch.start) |=> (ch.target >= $past(ch.floor))
            && (ch.target >= $past(ch.calc)))
        else $error("fan target below floor or span duty");

endmodule // fmd_duty_gate

// [hw/fmd_ramp.sv]
// Steps one fan drive duty toward its target at the selected rate
module fmd_ramp (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    // Channel
    fmd_ch_if.ramp    ch
);
    import fmd_pkg::*;

    logic [DUTY_W-1:0] duty_reg;
    logic [DUTY_W-1:0] duty_next;
    logic [DUTY_W-1:0] step;
    logic [DUTY_W-1:0] gap;

    always_comb begin
        step      = RAMP_STEP[ch.rate]; // R04
        gap       = DUTY_OFF;
        duty_next = duty_reg;
        if (!ch.on) begin
            duty_next = ch.target; // R14
        end else if (ch.tick) begin // R02
            if (ch.target > duty_reg) begin
                gap       = ch.target - duty_reg;
                duty_next = (gap <= step) ? ch.target : duty_reg + step;
            end else if (ch.target < duty_reg) begin
                gap       = duty_reg - ch.target;
                duty_next = (gap <= step) ? ch.target : duty_reg - step;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            duty_reg <= DUTY_OFF;
        end else begin
            duty_reg <= duty_next;
        end
    end

    assign ch.duty = duty_reg;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_direct_move: assert property ( // R14
        !ch.on |=> (ch.duty == $past(ch.target)))
        else $error("unramped output did not jump to target");

    chk_ramp_hold: assert property ( // R02
        (ch.on && !ch.tick) |=> $stable(ch.duty))
        else $error("ramped output moved outside a time slot");

    chk_ramp_up: assert property ( // R04
        (ch.on && ch.tick && ch.target > ch.duty) |=>
            (ch.duty > $past(ch.duty)) && (ch.duty <= $past(ch.target))
            && (ch.duty - $past(ch.duty) <= RAMP_STEP[$past(ch.rate)]))
        else $error("ramp up step wrong");

    chk_ramp_down: assert property ( // R04
        (ch.on && ch.tick && ch.target < ch.duty) |=>
            (ch.duty < $past(ch.duty)) && (ch.duty >= $past(ch.target))
            && ($past(ch.duty) - ch.duty <= RAMP_STEP[$past(ch.rate)]))
        else $error("ramp down step wrong");

endmodule // fmd_ramp

// [hw/fmd_ctrl.sv]
// Fan ramp rate, floor duty and start temperature controller top
//
// Summary of operation
// (R01) Bits 2:0 pick output 3 ramp rate
// (R02) Enabled ramp steps gradually toward new duty
// (R03) Bits 6:4 pick output 2 ramp rate
// (R04) Rate codes give steps 1,2,3,5,8,12,24,48
// (R05) Bit 3 enables ramping on output 3
// (R06) Bit 7 enables ramping on output 2
// (R07) Floor duty scales linearly, zero means off
// (R08) Floor duty writes ignored in automatic mode
// (R09) Acoustic register read-only once lock set (here only while cfg_lock_i is high, not latched)
// (R10) Three start temperatures, consecutive, default 90
// (R11) Above start temperature fan runs from floor
// (R12) Floor duty registers reset to half duty
// (R13) Output 1 ramp lives in another register
// (R14) Ramp disabled means direct jump to duty
module fmd_ctrl #(
    parameter int unsigned SLOT_CYCLES = fmd_pkg::SLOT_CYCLES_DFLT
) (
    // Clock and reset
    input  wire logic                         ref_clk_i,
    input  wire logic                         sys_rst_i,
    // Register port
    input  wire logic [fmd_pkg::ADDR_W-1:0]   reg_addr_i,
    input  wire logic [fmd_pkg::DUTY_W-1:0]   reg_wdata_i,
    input  wire logic                         reg_wr_i,
    input  wire logic                         reg_rd_i,
    output logic      [fmd_pkg::DUTY_W-1:0]   reg_rdata_o,
    // Mode inputs from the surrounding controller
    input  wire logic                         cfg_lock_i,
    input  wire logic                         auto_mode_i,
    // Measured temperatures
    input  wire logic [fmd_pkg::TEMP_W-1:0]   remote1_temp_i,
    input  wire logic [fmd_pkg::TEMP_W-1:0]   local_temp_i,
    input  wire logic [fmd_pkg::TEMP_W-1:0]   remote2_temp_i,
    // Span-derived duties
    input  wire logic [fmd_pkg::DUTY_W-1:0]   span_duty_1_i,
    input  wire logic [fmd_pkg::DUTY_W-1:0]   span_duty_2_i,
    input  wire logic [fmd_pkg::DUTY_W-1:0]   span_duty_3_i,
    // Fan drive duties
    output logic      [fmd_pkg::DUTY_W-1:0]   fan_drive_out_1_o,
    output logic      [fmd_pkg::DUTY_W-1:0]   fan_drive_out_2_o,
    output logic      [fmd_pkg::DUTY_W-1:0]   fan_drive_out_3_o
);
    import fmd_pkg::*;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [DUTY_W-1:0] acou_reg;
    logic [DUTY_W-1:0] acou_next;
    logic [DUTY_W-1:0] floor_reg  [NUM_CH];
    logic [DUTY_W-1:0] floor_next [NUM_CH];
    logic [TEMP_W-1:0] start_reg  [NUM_CH];
    logic [TEMP_W-1:0] start_next [NUM_CH];
    logic [DUTY_W-1:0] rdata_reg;
    logic [DUTY_W-1:0] rdata_next;

    logic [ADDR_W-1:0] floor_addr [NUM_CH];
    logic [ADDR_W-1:0] start_addr [NUM_CH];

    assign floor_addr[0] = ADDR_FLOOR_1;
    assign floor_addr[1] = ADDR_FLOOR_2;
    assign floor_addr[2] = ADDR_FLOOR_3;
    assign start_addr[0] = ADDR_START_1;
    assign start_addr[1] = ADDR_START_L;
    assign start_addr[2] = ADDR_START_2;

    always_comb begin
        acou_next  = acou_reg;
        floor_next = floor_reg;
        start_next = start_reg;
        rdata_next = RDATA_NONE;
        // Lock blocks acoustic and start writes only while cfg_lock_i is high; it is not latched
        if (reg_wr_i && !cfg_lock_i && reg_addr_i == ADDR_ACOU_B) begin
            acou_next = reg_wdata_i; // R09
        end
        for (int i = 0; i < NUM_CH; i++) begin
            // Auto mode owns the floors, so software cannot pull them
            if (reg_wr_i && !auto_mode_i
                && reg_addr_i == floor_addr[i]) begin
                floor_next[i] = reg_wdata_i; // R08
            end
            if (reg_wr_i && !cfg_lock_i
                && reg_addr_i == start_addr[i]) begin
                start_next[i] = reg_wdata_i; // R10
            end
        end
        if (reg_rd_i) begin
            if (reg_addr_i == ADDR_ACOU_B) begin
                rdata_next = acou_reg;
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (reg_addr_i == floor_addr[i]) begin
                    rdata_next = floor_reg[i];
                end
                if (reg_addr_i == start_addr[i]) begin
                    rdata_next = start_reg[i]; // R10
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            acou_reg  <= RST_ACOU_B;
            rdata_reg <= RDATA_NONE;
            for (int i = 0; i < NUM_CH; i++) begin
                floor_reg[i] <= RST_FLOOR; // R12
                start_reg[i] <= RST_START; // R10
            end
        end else begin
            acou_reg   <= acou_next;
            rdata_reg  <= rdata_next;
            floor_reg  <= floor_next;
            start_reg  <= start_next;
        end
    end

    assign reg_rdata_o = rdata_reg;

    // ------------------------------------------------------------
    // Time slot generator
    // ------------------------------------------------------------
    // One shared slot keeps both ramped outputs in step with each other
    logic [SLOT_CNT_W-1:0] slot_cnt_reg;
    logic [SLOT_CNT_W-1:0] slot_cnt_next;
    logic                  tick_reg;
    logic                  tick_next;

    always_comb begin
        tick_next     = 1'b0;
        slot_cnt_next = slot_cnt_reg + SLOT_CNT_W'(1);
        if (slot_cnt_reg == SLOT_CNT_W'(SLOT_CYCLES - 1)) begin
            slot_cnt_next = '0;
            tick_next     = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            slot_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end else begin
            slot_cnt_reg <= slot_cnt_next;
            tick_reg     <= tick_next;
        end
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    logic [TEMP_W-1:0] temp_arr [NUM_CH];
    logic [DUTY_W-1:0] span_arr [NUM_CH];
    logic              on_arr   [NUM_CH];
    logic [RATE_W-1:0] rate_arr [NUM_CH];

    assign temp_arr[0] = remote1_temp_i;
    assign temp_arr[1] = local_temp_i;
    assign temp_arr[2] = remote2_temp_i;
    assign span_arr[0] = span_duty_1_i;
    assign span_arr[1] = span_duty_2_i;
    assign span_arr[2] = span_duty_3_i;

    // Output 1 has its ramp controls elsewhere, so here it always jumps
    assign on_arr[0]   = 1'b0; // R13
    assign rate_arr[0] = '0;
    assign on_arr[1]   = acou_reg[OUT2_ON_BIT]; // R06
    assign rate_arr[1] = acou_reg[OUT2_RATE_LSB +: RATE_W]; // R03
    assign on_arr[2]   = acou_reg[OUT3_ON_BIT]; // R05
    assign rate_arr[2] = acou_reg[OUT3_RATE_LSB +: RATE_W]; // R01

    fmd_ch_if ch_if [NUM_CH] ();

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        assign ch_if[g].temp  = temp_arr[g];
        assign ch_if[g].start = start_reg[g];
        assign ch_if[g].floor = floor_reg[g];
        assign ch_if[g].calc  = span_arr[g];
        assign ch_if[g].on    = on_arr[g];
        assign ch_if[g].rate  = rate_arr[g];
        assign ch_if[g].tick  = tick_reg;

        fmd_duty_gate u_gate (
            .ref_clk_i (ref_clk_i),
            .sys_rst_i (sys_rst_i),
            .ch        (ch_if[g])
        );

        fmd_ramp u_ramp (
            .ref_clk_i (ref_clk_i),
            .sys_rst_i (sys_rst_i),
            .ch        (ch_if[g])
        );
    end

    // Duties come straight from the ramp flip-flops
    assign fan_drive_out_1_o = ch_if[0].duty;
    assign fan_drive_out_2_o = ch_if[1].duty;
    assign fan_drive_out_3_o = ch_if[2].duty;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    // Tracks which floors software has written since reset
    logic [NUM_CH-1:0] floor_wr_seen_reg;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            floor_wr_seen_reg <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (reg_wr_i && reg_addr_i == floor_addr[i]) begin
                    floor_wr_seen_reg[i] <= 1'b1;
                end
            end
        end
    end

    sequence seq_acou_wr;
        reg_wr_i && reg_addr_i == ADDR_ACOU_B;
    endsequence

    sequence seq_acou_rd;
        reg_rd_i && reg_addr_i == ADDR_ACOU_B;
    endsequence

    chk_acou_lock: assert property ( // R09
        (seq_acou_wr and cfg_lock_i) |=> $stable(acou_reg))
        else $error("acoustic register written while locked");

    chk_acou_write: assert property ( // R05
        (seq_acou_wr and !cfg_lock_i) |=>
            (on_arr[2] == $past(reg_wdata_i[OUT3_ON_BIT]))
            && (on_arr[1] == $past(reg_wdata_i[OUT2_ON_BIT])))
        else $error("ramp enable bits not taken from write");

    chk_rate_fields: assert property ( // R01
        (seq_acou_wr and !cfg_lock_i) |=>
            (rate_arr[2] == $past(reg_wdata_i[OUT3_RATE_LSB +: RATE_W]))
            && (rate_arr[1] == $past(reg_wdata_i[OUT2_RATE_LSB +: RATE_W])))
        else $error("ramp rate fields not taken from write");

    chk_acou_readback: assert property ( // R03
        (seq_acou_wr and !cfg_lock_i) ##1 (seq_acou_rd and !reg_wr_i)
            |=> (reg_rdata_o == $past(reg_wdata_i, 2)))
        else $error("acoustic register read back wrong");

    chk_out1_direct: assert property ( // R13
        ##1 (fan_drive_out_1_o == $past(ch_if[0].target)))
        else $error("output 1 was ramped");

    chk_rdata_idle: assert property ( // R10
        !reg_rd_i |=> (reg_rdata_o == RDATA_NONE))
        else $error("read data not cleared outside a read");

    chk_tick_phase: assert property ( // R02
        tick_reg |-> (slot_cnt_reg == '0))
        else $error("slot tick out of phase with slot counter");

    chk_out2_direct: assert property ( // R06
        !acou_reg[OUT2_ON_BIT]
            |=> (fan_drive_out_2_o == $past(ch_if[1].target)))
        else $error("output 2 ramped while its ramp is off");

    chk_out3_direct: assert property ( // R05
        !acou_reg[OUT3_ON_BIT]
            |=> (fan_drive_out_3_o == $past(ch_if[2].target)))
        else $error("output 3 ramped while its ramp is off");

    for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
        chk_floor_auto: assert property ( // R08
            (reg_wr_i && auto_mode_i && reg_addr_i == floor_addr[g])
                |=> $stable(floor_reg[g]))
            else $error("floor duty written in automatic mode");

        chk_floor_reset: assert property ( // R12
            !floor_wr_seen_reg[g] |-> (floor_reg[g] == RST_FLOOR))
            else $error("floor duty not at half duty after reset");

        chk_start_read: assert property ( // R10
            (reg_rd_i && reg_addr_i == start_addr[g])
                |=> (reg_rdata_o == $past(start_reg[g])))
            else $error("start temperature read back wrong");

        chk_floor_write: assert property ( // R07
            (reg_wr_i && !auto_mode_i && reg_addr_i == floor_addr[g])
                |=> (floor_reg[g] == $past(reg_wdata_i)))
            else $error("floor duty write not taken");

        chk_start_write: assert property ( // R10
            (reg_wr_i && !cfg_lock_i && reg_addr_i == start_addr[g])
                |=> (start_reg[g] == $past(reg_wdata_i)))
            else $error("start temperature write not taken");

        chk_start_lock: assert property ( // R10
            (reg_wr_i && cfg_lock_i && reg_addr_i == start_addr[g])
                |=> $stable(start_reg[g]))
            else $error("start temperature written while locked");
    end

endmodule // fmd_ctrl

// [sim/fmd_fan_model.sv]
// Behavioural fan that watches one drive duty and reports its changes
module fmd_fan_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Drive duty from the controller
    input  wire logic [7:0] duty_i,
    // Observations
    output logic      [7:0] last_step_o,
    output logic      [7:0] gap_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] prev_reg;
    logic [7:0] cnt_reg;

    // ------------------------------------------------------------
    // Change watcher
    // ------------------------------------------------------------
    // A real fan only feels duty steps, so size and spacing are kept
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_reg    <= 8'h00;
            cnt_reg     <= 8'h00;
            last_step_o <= 8'h00;
            gap_o       <= 8'h00;
        end else begin
            prev_reg <= duty_i;
            cnt_reg  <= (cnt_reg == 8'hFF) ? cnt_reg : cnt_reg + 8'h01;
            if (duty_i != prev_reg) begin
                last_step_o <= (duty_i > prev_reg) ? duty_i - prev_reg
                                                   : prev_reg - duty_i;
                gap_o       <= cnt_reg + 8'h01;
                cnt_reg     <= 8'h00;
            end
        end
    end
endmodule // fmd_fan_model

// [sim/tb.sv]
// Self-checking testbench for the fan ramp and floor duty controller
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fmd_pkg::*;

    localparam int unsigned SLOT  = 8;
    localparam int          LIMIT = 5000;

    logic       ref_clk_i;
    logic       sys_rst_i;
    logic       reg_wr;
    logic       reg_rd;
    logic       lock;
    logic       auto_m;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] tmp;
    logic [7:0] spn;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [7:0] d3;
    logic [7:0] v;
    logic [7:0] last_step [1:3];
    logic [7:0] gap       [1:3];
    logic [7:0] steps     [0:7] = '{8'h01, 8'h02, 8'h03, 8'h05,
                                    8'h08, 8'h0C, 8'h18, 8'h30};
    int         failures;
    int         compares;
    int         cyc;

    fmd_ctrl #(.SLOT_CYCLES(SLOT)) i_dut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
        .cfg_lock_i(lock), .auto_mode_i(auto_m),
        .remote1_temp_i(tmp), .local_temp_i(tmp), .remote2_temp_i(tmp),
        .span_duty_1_i(spn), .span_duty_2_i(spn), .span_duty_3_i(spn),
        .fan_drive_out_1_o(d1), .fan_drive_out_2_o(d2),
        .fan_drive_out_3_o(d3)
    );

    fmd_fan_model i_fan1 (.clk_i(ref_clk_i), .rst_i(sys_rst_i), .duty_i(d1),
        .last_step_o(last_step[1]), .gap_o(gap[1]));
    fmd_fan_model i_fan2 (.clk_i(ref_clk_i), .rst_i(sys_rst_i), .duty_i(d2),
        .last_step_o(last_step[2]), .gap_o(gap[2]));
    fmd_fan_model i_fan3 (.clk_i(ref_clk_i), .rst_i(sys_rst_i), .duty_i(d3),
        .last_step_o(last_step[3]), .gap_o(gap[3]));

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            failures++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_wr <= 1'b1;
        addr   <= a;
        wdata  <= d;
        @(posedge ref_clk_i);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
                          input string what);
        @(posedge ref_clk_i);
        reg_rd <= 1'b1;
        addr   <= a;
        @(posedge ref_clk_i);
        reg_rd <= 1'b0;
        #1;
        check(what, rdata, exp);
    endtask

    // Write then read back with no gap, as the port allows
    task automatic wr_rd_chk(input logic [7:0] a, input logic [7:0] d,
                             input string what);
        @(posedge ref_clk_i);
        reg_wr <= 1'b1;
        addr   <= a;
        wdata  <= d;
        @(posedge ref_clk_i);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd <= 1'b0;
        #1;
        check(what, rdata, d);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic set_in(input logic [7:0] t, input logic [7:0] s);
        @(posedge ref_clk_i);
        tmp <= t;
        spn <= s;
        settle(4);
    endtask

    // Bounded wait for fan 2 to move; a stuck output returns its unchanged duty in v
    task automatic wait_move(output logic [7:0] val);
        logic [7:0] p;
        p = d2;
        for (int n = 0; n < SLOT + 6; n++) begin
            @(posedge ref_clk_i);
            #1;
            if (d2 !== p)
                break;
        end
        val = d2;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        lock   = 1'b0;
        auto_m = 1'b0;
        addr   = 8'h00;
        wdata  = 8'h00;
        tmp    = 8'h50;
        spn    = 8'h00;
        sys_rst_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        rd_chk(ADDR_ACOU_B, 8'h00, "acoustic reset");
        for (int a = 8'h64; a <= 8'h66; a++)
            rd_chk(8'(a), 8'h80, "floor reset");
        for (int a = 8'h67; a <= 8'h69; a++)
            rd_chk(8'(a), 8'h5A, "start reset");
        rd_chk(8'h70, 8'h00, "unmapped read");
        @(posedge ref_clk_i);
        auto_m <= 1'b1;
        wr(8'h65, 8'h11);
        rd_chk(8'h65, 8'h80, "floor in auto");
        @(posedge ref_clk_i);
        auto_m <= 1'b0;
        wr(8'h64, 8'h00);
        rd_chk(8'h64, 8'h00, "floor write");
        set_in(8'h70, 8'h00);
        check("fan1 off", d1, 8'h00);
        wr(8'h64, 8'hFF);
        settle(4);
        check("fan1 full", d1, 8'hFF);
        wr(8'h64, 8'h80);
        set_in(8'h70, 8'h40);
        check("fan1 floor", d1, 8'h80);
        set_in(8'h5A, 8'h40);
        check("fan1 at start", d1, 8'h00);
        set_in(8'h5B, 8'hC0);
        check("fan1 span", d1, 8'hC0);
        check("fan2 direct", d2, 8'hC0);
        check("fan3 direct", d3, 8'hC0);
        @(posedge ref_clk_i);
        lock <= 1'b1;
        wr(8'h63, 8'h55);
        rd_chk(8'h63, 8'h00, "acoustic locked");
        wr(8'h68, 8'h10);
        rd_chk(8'h68, 8'h5A, "start locked");
        @(posedge ref_clk_i);
        lock <= 1'b0;
        wr_rd_chk(8'h63, 8'h8B, "acoustic write");
        wr_rd_chk(8'h67, 8'h5B, "start write");
        for (int c = 0; c < 8; c++) begin
            wr(8'h63, 8'h00);
            set_in(8'h50, 8'hC0);
            check("fan2 drop", d2, 8'h00);
            check("fan3 drop", d3, 8'h00);
            wr(8'h63, {1'b1, 3'(c), 1'b1, 3'(c)});
            @(posedge ref_clk_i);
            tmp <= 8'h70;
            wait_move(v);
            check("fan2 first step", v, steps[c]);
            check("fan3 first step", d3, steps[c]);
            check("fan1 no ramp", d1, 8'hC0);
            wait_move(v);
            check("fan2 second step", v, steps[c] << 1);
            settle(1);
            check("fan2 step gap", gap[2], 8'(SLOT));
            check("fan3 step size", last_step[3], steps[c]);
            check("fan2 step size", last_step[2], steps[c]);
            @(posedge ref_clk_i);
            tmp <= 8'h50;
            wait_move(v);
            check("fan2 ramp down", v, steps[c]);
        end
        give_verdict();
    end
endmodule // tb
